// ### logic/scs_ontime_mon.sv
`timescale 1ns/1ns
`default_nettype none
module scs_ontime_mon (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       enable,
	input  wire logic       pwm_on,
	input  wire logic [9:0] limit,
	input  wire logic [4:0] unit_log2,
	output logic            exceeded
);
	// ************************************************************
	// on-time counter, pulse when limit passed
	// ************************************************************
	logic [17:0] cnt_q;
	logic [17:0] lim_clks;
	assign lim_clks = 18'({8'h00, limit} << unit_log2);

	always_ff @(posedge clk) begin
		if (rst || !pwm_on || !enable) begin
			cnt_q <= 18'h00000;
		end else if (cnt_q != 18'h3ffff) begin
			cnt_q <= cnt_q + 18'h00001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			exceeded <= 1'b0;
		end else begin
			exceeded <= enable && pwm_on && (limit != 10'h000) && (cnt_q == lim_clks);
		end
	end
endmodule // scs_ontime_mon
`default_nettype wire

// ### logic/scs_pkg.sv
package scs_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0]  ADDR_COMM_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_PWM_AMP     = 8'h04;
	localparam logic [7:0]  ADDR_STATUS      = 8'h08;
	localparam logic [7:0]  ADDR_CONFIG      = 8'h0c;
	localparam logic [7:0]  ADDR_COMMUTATION_MIN_VELOCITY      = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h14;
	localparam logic [7:0]  ADDR_IRQ_ENABLE  = 8'h18;
	localparam logic [7:0]  ADDR_IRQ_CLEAR   = 8'h1c;
	// ************************************************************
	// fields
	// ************************************************************
	localparam int          CC_WIDTH         = 24;
	localparam int          ONT_LSB          = 0;
	localparam int          ONT_W            = 10;
	localparam int          SGL_LSB          = 16;
	localparam int          SGL_W            = 8;
	localparam int          SGL_UNIT_LOG2    = 4;
	localparam int          AMP_W            = 8;
	localparam int          LOAD_W           = 10;
	localparam int          VEL_W            = 23;
	localparam logic [22:0] COMMUTATION_MIN_VELOCITY_FLOOR     = 23'h000100;
	localparam int          ST_STANDSTILL    = 31;
	localparam int          ST_OPEN_B        = 30;
	localparam int          ST_OPEN_A        = 29;
	localparam int          ST_SHORT_B       = 28;
	localparam int          ST_SHORT_A       = 27;
	localparam int          ST_OT_WARN       = 26;
	localparam int          ST_OT            = 25;
	localparam int          ST_STALL         = 24;
	localparam int          CFG_OFF_TIME_SETTING_LSB     = 0;
	localparam int          CFG_OFF_TIME_SETTING_W       = 4;
	localparam int          CFG_HIGHFS       = 4;
	localparam int          IRQ_W            = 6;
	localparam logic [23:0] CC_RESET         = 24'h000000;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int          STANDSTILL_CLKS  = 1 << 20;
	localparam int          STST_CNT_W       = 21;
endpackage

// ### logic/scs_stepper_commutation_status.sv
// Operation
// [R1] 24-bit write-only word, on-time limit bits 9:0
// [R2] bits 23:16 step-loss limit, 16 clocks, 0 off
// [R3] software sets limits above blank time
// [R4] commutation enabled by pin or velocity threshold
// [R5] step-loss stays active above high threshold
// [R6] 8-bit read-only amplitude, 255 is maximum
// [R7] amplitude scaler usable for stall detection
// [R8] standstill bit 31 after 2^20 clocks
// [R9] open-load bits 30/29, informative only
// [R10] software checks open load at slow motion
// [R11] short bits 28/27 disable the driver
// [R12] short flags held until driver disabled
// [R13] pre-warning bit 26 shared by both bridges
// [R14] overtemp bit 25 holds disable until cool
// [R15] stall bit 24 from zero load or commutation
// [R16] commutation on at velocity above threshold
// [R17] status and amplitude writes ignored
`timescale 1ns/1ns
`default_nettype none
module scs_stepper_commutation_status (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic        step_pulse,
	input  wire logic        commutation_enable_pin,
	input  wire logic        driver_enable_n_input,
	input  wire logic [22:0] actual_velocity,
	input  wire logic        above_high_velocity,
	input  wire logic        pwm_on,
	input  wire logic        voltage_mode,
	input  wire logic [7:0]  pwm_amplitude,
	input  wire logic [9:0]  load_measure_result,
	input  wire logic        load_valid,
	input  wire logic        open_load_coil_a,
	input  wire logic        open_load_coil_b,
	input  wire logic        ground_short_coil_a_det,
	input  wire logic        ground_short_coil_b_det,
	input  wire logic        overtemp_warn_det,
	input  wire logic        overtemp_det,
	output logic             sensorless_commutation,
	output logic             commutation_advance,
	output logic             bridge_enable,
	output logic             irq
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	localparam int NSYNC = 10;
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] s1_q;
	logic [NSYNC-1:0] s2_q;
	assign pin_raw = {step_pulse, commutation_enable_pin, driver_enable_n_input,
		above_high_velocity, pwm_on, open_load_coil_a, open_load_coil_b,
		ground_short_coil_a_det, ground_short_coil_b_det, overtemp_warn_det};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
				end
			end
		end
	endgenerate
	logic ot_s1_q;
	logic ot_s2_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			ot_s1_q <= 1'b0;
			ot_s2_q <= 1'b0;
		end else begin
			ot_s1_q <= overtemp_det;
			ot_s2_q <= ot_s1_q;
		end
	end
	logic step_s;
	logic commutation_enable_pin_s;
	logic enn_s;
	logic high_s;
	logic pwm_s;
	logic ola_s;
	logic olb_s;
	logic ground_short_coil_a_s;
	logic ground_short_coil_b_s;
	logic otpw_s;
	assign {step_s, commutation_enable_pin_s, enn_s, high_s, pwm_s, ola_s, olb_s, ground_short_coil_a_s, ground_short_coil_b_s, otpw_s} = s2_q;

	// ************************************************************
	// registers
	// ************************************************************
	logic [23:0]                   comm_ctrl_q;
	logic [scs_pkg::CFG_OFF_TIME_SETTING_W-1:0] off_time_setting_q;
	logic                          highfs_q;
	logic [22:0]                   commutation_min_velocity_q;
	logic [scs_pkg::IRQ_W-1:0]     irq_en_q;
	logic [9:0]                    on_time_limit;
	logic [7:0]                    step_loss_limit;
	assign on_time_limit   = comm_ctrl_q[scs_pkg::ONT_LSB +: scs_pkg::ONT_W];
	assign step_loss_limit = comm_ctrl_q[scs_pkg::SGL_LSB +: scs_pkg::SGL_W];

	function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
		hit = (a == b);
	endfunction

	always_ff @(posedge clk) begin
		if (rst) begin
			comm_ctrl_q <= scs_pkg::CC_RESET;
		end else if (wr && hit(addr, scs_pkg::ADDR_COMM_CTRL)) begin
			comm_ctrl_q <= wdata[23:0]; // [R1]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			off_time_setting_q   <= 4'h0;
			highfs_q <= 1'b0;
			commutation_min_velocity_q <= 23'h000000;
			irq_en_q <= 6'h00;
		end else if (wr) begin
			if (hit(addr, scs_pkg::ADDR_CONFIG)) begin
				off_time_setting_q   <= wdata[scs_pkg::CFG_OFF_TIME_SETTING_LSB +: scs_pkg::CFG_OFF_TIME_SETTING_W];
				highfs_q <= wdata[scs_pkg::CFG_HIGHFS];
			end
			if (hit(addr, scs_pkg::ADDR_COMMUTATION_MIN_VELOCITY)) begin
				commutation_min_velocity_q <= wdata[22:0];
			end
			if (hit(addr, scs_pkg::ADDR_IRQ_ENABLE)) begin
				irq_en_q <= wdata[scs_pkg::IRQ_W-1:0];
			end
		end
	end

	// ************************************************************
	// commutation enable
	// ************************************************************
	logic vel_on;
	assign vel_on = (commutation_min_velocity_q >= scs_pkg::COMMUTATION_MIN_VELOCITY_FLOOR) &&
		(actual_velocity[22:8] >= commutation_min_velocity_q[22:8]); // [R16]
	always_ff @(posedge clk) begin
		if (rst) begin
			sensorless_commutation <= 1'b0;
		end else begin
			sensorless_commutation <= commutation_enable_pin_s || vel_on; // [R4]
		end
	end

	logic ot_limit_hit;
	logic step_loss_en;
	logic step_loss_hit;
	assign step_loss_en = (sensorless_commutation || (high_s && highfs_q)) &&
		(step_loss_limit != 8'h00); // [R2] [R5]

	scs_ontime_mon u_comm_mon (
		.clk       (clk),
		.rst       (rst),
		.enable    (sensorless_commutation),
		.pwm_on    (pwm_s),
		.limit     (on_time_limit),
		.unit_log2 (5'h00),
		.exceeded  (ot_limit_hit)
	);
	scs_ontime_mon u_loss_mon (
		.clk       (clk),
		.rst       (rst),
		.enable    (step_loss_en),
		.pwm_on    (pwm_s),
		.limit     ({2'b00, step_loss_limit}),
		.unit_log2 (5'(scs_pkg::SGL_UNIT_LOG2)),
		.exceeded  (step_loss_hit)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			commutation_advance <= 1'b0;
		end else begin
			commutation_advance <= ot_limit_hit; // [R1]
		end
	end

	// ************************************************************
	// standstill
	// ************************************************************
	logic [scs_pkg::STST_CNT_W-1:0] stst_cnt_q;
	logic                           step_d_q;
	logic                           stst_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			step_d_q   <= 1'b0;
			stst_cnt_q <= '0;
			stst_q     <= 1'b0;
		end else begin
			step_d_q <= step_s;
			if (step_s && !step_d_q) begin
				stst_cnt_q <= '0;
				stst_q     <= 1'b0;
			end else if (stst_cnt_q == 21'(scs_pkg::STANDSTILL_CLKS - 1)) begin
				stst_q <= 1'b1; // [R8]
			end else begin
				stst_cnt_q <= stst_cnt_q + 21'h000001;
			end
		end
	end

	// ************************************************************
	// protection flags
	// ************************************************************
	logic drv_disabled;
	logic ground_short_coil_a_q;
	logic ground_short_coil_b_q;
	logic ot_q;
	logic stall_q;
	logic amp_stall;
	assign drv_disabled = (off_time_setting_q == 4'h0) || enn_s;
	assign amp_stall    = voltage_mode && (pwm_amplitude == 8'hff) && pwm_s; // [R7]

	always_ff @(posedge clk) begin
		if (rst) begin
			ground_short_coil_a_q <= 1'b0;
			ground_short_coil_b_q <= 1'b0;
		end else begin
			ground_short_coil_a_q <= ground_short_coil_a_s || (ground_short_coil_a_q && !drv_disabled); // [R12]
			ground_short_coil_b_q <= ground_short_coil_b_s || (ground_short_coil_b_q && !drv_disabled); // [R12]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ot_q <= 1'b0;
		end else begin
			ot_q <= ot_s2_q || (ot_q && otpw_s); // [R14]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			stall_q <= 1'b0;
		end else begin
			stall_q <= (load_valid && load_measure_result == 10'h000) ||
				step_loss_hit || amp_stall; // [R15]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			bridge_enable <= 1'b0;
		end else begin
			bridge_enable <= !drv_disabled && !ground_short_coil_a_q && !ground_short_coil_b_q && !ot_q; // [R11] [R14] [R9]
		end
	end

	// ************************************************************
	// status word and interrupts
	// ************************************************************
	logic [31:0] status;
	always_comb begin
		status = 32'h00000000;
		status[scs_pkg::ST_STANDSTILL] = stst_q;
		status[scs_pkg::ST_OPEN_B]     = olb_s; // [R9]
		status[scs_pkg::ST_OPEN_A]     = ola_s; // [R9]
		status[scs_pkg::ST_SHORT_B]    = ground_short_coil_b_q; // [R11]
		status[scs_pkg::ST_SHORT_A]    = ground_short_coil_a_q; // [R11]
		status[scs_pkg::ST_OT_WARN]    = otpw_s; // [R13]
		status[scs_pkg::ST_OT]         = ot_q; // [R14]
		status[scs_pkg::ST_STALL]      = stall_q; // [R15]
		status[scs_pkg::LOAD_W-1:0]    = load_measure_result;
	end

	logic [scs_pkg::IRQ_W-1:0] irq_ev;
	logic [scs_pkg::IRQ_W-1:0] irq_st_q;
	logic [scs_pkg::IRQ_W-1:0] irq_clr;
	assign irq_ev  = {stst_q, ground_short_coil_b_q, ground_short_coil_a_q, otpw_s, ot_q, stall_q};
	assign irq_clr = (wr && hit(addr, scs_pkg::ADDR_IRQ_CLEAR)) ?
		wdata[scs_pkg::IRQ_W-1:0] : 6'h00;
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_st_q <= 6'h00;
		end else begin
			irq_st_q <= irq_ev | (irq_st_q & ~irq_clr);
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |((irq_ev | (irq_st_q & ~irq_clr)) & irq_en_q);
		end
	end

	// ************************************************************
	// read port
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			unique case (addr)
				scs_pkg::ADDR_PWM_AMP:    rdata <= {24'h000000, pwm_amplitude}; // [R6]
				scs_pkg::ADDR_STATUS:     rdata <= status;
				scs_pkg::ADDR_CONFIG:     rdata <= {27'h0000000, highfs_q, off_time_setting_q};
				scs_pkg::ADDR_COMMUTATION_MIN_VELOCITY:     rdata <= {9'h000, commutation_min_velocity_q};
				scs_pkg::ADDR_IRQ_STATUS: rdata <= {26'h0000000, irq_st_q};
				scs_pkg::ADDR_IRQ_ENABLE: rdata <= {26'h0000000, irq_en_q};
				default:                  rdata <= 32'h00000000; // [R17]
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end
endmodule // scs_stepper_commutation_status
`default_nettype wire

// ### verif/scs_coil_model.sv
`timescale 1ns/1ns
`default_nettype none
module scs_coil_model (
	input  wire logic       clk,
	input  wire logic       bridge_enable,
	input  wire logic [7:0] on_len,
	output logic            pwm_on
);
	// ****
	// coil current on phase
	// ****
	logic [7:0] cnt_q = 8'h00;
	// on_len clocks on, then one clock off
	always @(posedge clk) begin
		cnt_q <= (cnt_q >= on_len) ? 8'h00 : cnt_q + 8'h01;
		pwm_on <= bridge_enable && (cnt_q < on_len);
	end
endmodule // scs_coil_model
`default_nettype wire

// ### verif/scs_stepper_commutation_status_sva.sv
`timescale 1ns/1ns
`default_nettype none
module scs_sva_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        step_pulse,
	input wire logic        commutation_enable_pin,
	input wire logic        driver_enable_n_input,
	input wire logic [22:0] actual_velocity,
	input wire logic        ground_short_coil_a_det,
	input wire logic        overtemp_warn_det,
	input wire logic        overtemp_det,
	input wire logic        sensorless_commutation,
	input wire logic        commutation_advance,
	input wire logic        bridge_enable,
	input wire logic        irq
);
	// ****
	// helper state
	// ****
	logic [5:0]  irq_en_q;
	logic [10:0] quiet_q;
	always_ff @(posedge clk) begin
		if (rst)
			irq_en_q <= 6'h00;
		else if (wr && addr == scs_pkg::ADDR_IRQ_ENABLE)
			irq_en_q <= wdata[5:0];
	end
	always_ff @(posedge clk) begin
		if (rst || step_pulse)
			quiet_q <= 11'h000;
		else if (!quiet_q[10])
			quiet_q <= quiet_q + 11'h001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence ot_hot;
		(overtemp_det && overtemp_warn_det)[*2] ##1 overtemp_warn_det[*6];
	endsequence
	sequence st_rd;
		rd && addr == scs_pkg::ADDR_STATUS && !quiet_q[10];
	endsequence
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data without read");
	wo_read_a: assert property (rd && addr == 8'h00 |=> rdata == 32'h0)
		else $error("control word readable");
	stst_quiet_a: assert property (st_rd |=> !rdata[31])
		else $error("standstill too early");
	enn_off_a: assert property (driver_enable_n_input[*4] |-> !bridge_enable)
		else $error("bridge on while disabled");
	short_off_a: assert property (ground_short_coil_a_det[*4] |=> !bridge_enable)
		else $error("bridge on during short");
	ot_hold_a: assert property (ot_hot |-> !bridge_enable)
		else $error("bridge on before cooling");
	dc_pin_a: assert property (commutation_enable_pin[*5] |-> sensorless_commutation)
		else $error("pin did not enable commutation");
	dc_slow_a: assert property ((!commutation_enable_pin
		&& actual_velocity[22:8] == 15'h0)[*5] |-> !sensorless_commutation)
		else $error("commutation on at low velocity");
	adv_pulse_a: assert property (commutation_advance |=> !commutation_advance)
		else $error("advance longer than one clock");
	irq_lvl_a: assert property (rd && addr == scs_pkg::ADDR_IRQ_STATUS
		##1 (rdata[5:0] & irq_en_q) != 6'h0 |-> irq)
		else $error("irq low with enabled event");
endmodule // scs_sva_checker
bind scs_stepper_commutation_status scs_sva_checker i_chk (.*);
`default_nettype wire

// ### verif/scs_stepper_commutation_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module scs_stepper_commutation_status_tb;
	// ****
	// signals
	// ****
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [22:0] actual_velocity = 23'h0;
	logic [7:0]  pwm_amplitude = 8'h00;
	logic [9:0]  load_measure_result = 10'h155;
	logic [7:0]  on_len = 8'h04;
	logic        step_pulse = 1'b0, commutation_enable_pin = 1'b0, driver_enable_n_input = 1'b0;
	logic        above_high_velocity = 1'b0, voltage_mode = 1'b0, load_valid = 1'b0;
	logic        open_load_coil_a = 1'b0, open_load_coil_b = 1'b0, overtemp_det = 1'b0;
	logic        ground_short_coil_a_det = 1'b0, ground_short_coil_b_det = 1'b0;
	logic        overtemp_warn_det = 1'b0, irq;
	logic        pwm_on, sensorless_commutation, commutation_advance, bridge_enable;
	logic [31:0] rdata, r;
	int          fail_count = 0, check_count = 0, cycles = 0, adv_n = 0, i;
	integer      seed = 32'h1c8c141e;
	logic [22:0] vel [5] = '{23'h0, 23'h300, 23'h1ff, 23'h200, 23'h7fffff};
	logic [31:0] thr [5] = '{32'h200, 32'h200, 32'h200, 32'h200, 32'h0ff};
	logic [4:0]  dc_exp = 5'b01011;
	scs_stepper_commutation_status i_dut (.*);
	scs_coil_model i_coil (.clk(clk), .bridge_enable(bridge_enable), .on_len(on_len), .pwm_on(pwm_on));
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (commutation_advance === 1'b1)
			adv_n++;
		if (cycles == 20000) begin
			fail_count++;
			summarize();
		end
	end
	// ****
	// tasks
	// ****
	task automatic summarize;
		if (fail_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		chk(rdata & m, e);
	endtask
	// ****
	// sequence
	// ****
	initial begin
		cyc(12);
		rst <= 1'b0;
		rchk(scs_pkg::ADDR_STATUS, 32'hff00_0000, 32'h0);
		wr_reg(scs_pkg::ADDR_CONFIG, 32'h3);
		for (i = 0; i < 8; i++) begin
			r = $random(seed);
			if (i == 7)
				r[7:0] = 8'hff;
			pwm_amplitude <= r[7:0];
			step_pulse <= r[8];
			wr_reg(scs_pkg::ADDR_COMM_CTRL, r & 32'hff_03ff);
			wr_reg(scs_pkg::ADDR_PWM_AMP, ~r);
			wr_reg(scs_pkg::ADDR_STATUS, 32'hffff_ffff);
			rchk(scs_pkg::ADDR_PWM_AMP, 32'hff, {24'h0, r[7:0]});
			rchk(scs_pkg::ADDR_COMM_CTRL, 32'hffff_ffff, 32'h0);
			rchk(scs_pkg::ADDR_STATUS, 32'h7f00_0000, 32'h0);
		end
		step_pulse <= 1'b0;
		{open_load_coil_b, open_load_coil_a} <= 2'b11;
		cyc(4);
		rchk(scs_pkg::ADDR_STATUS, 32'h6000_0000, 32'h6000_0000);
		chk(32'(bridge_enable), 32'h1);
		{open_load_coil_b, open_load_coil_a} <= 2'b00;
		for (i = 0; i < 2; i++) begin
			{ground_short_coil_b_det, ground_short_coil_a_det} <= 2'(i + 1);
			cyc(4);
			{ground_short_coil_b_det, ground_short_coil_a_det} <= 2'b00;
			cyc(4);
			rchk(scs_pkg::ADDR_STATUS, 32'h1800_0000, 32'h0800_0000 << i);
			chk(32'(bridge_enable), 32'h0);
			if (i == 0)
				driver_enable_n_input <= 1'b1;
			else
				wr_reg(scs_pkg::ADDR_CONFIG, 32'h0);
			cyc(5);
			driver_enable_n_input <= 1'b0;
			wr_reg(scs_pkg::ADDR_CONFIG, 32'h3);
			cyc(4);
			rchk(scs_pkg::ADDR_STATUS, 32'h1800_0000, 32'h0);
			chk(32'(bridge_enable), 32'h1);
		end
		{overtemp_warn_det, overtemp_det} <= 2'b11;
		cyc(4);
		overtemp_det <= 1'b0;
		cyc(4);
		rchk(scs_pkg::ADDR_STATUS, 32'h0600_0000, 32'h0600_0000);
		chk(32'(bridge_enable), 32'h0);
		overtemp_warn_det <= 1'b0;
		cyc(5);
		chk(32'(bridge_enable), 32'h1);
		wr_reg(scs_pkg::ADDR_IRQ_CLEAR, 32'h3f);
		wr_reg(scs_pkg::ADDR_IRQ_ENABLE, 32'h1);
		{load_valid, load_measure_result} <= 11'h400;
		cyc(3);
		rchk(scs_pkg::ADDR_STATUS, 32'h0100_03ff, 32'h0100_0000);
		{load_valid, load_measure_result} <= 11'h155;
		cyc(3);
		chk(32'(irq), 32'h1);
		wr_reg(scs_pkg::ADDR_IRQ_ENABLE, 32'h0);
		cyc(2);
		chk(32'(irq), 32'h0);
		wr_reg(scs_pkg::ADDR_IRQ_CLEAR, 32'h1);
		rchk(scs_pkg::ADDR_IRQ_STATUS, 32'h1, 32'h0);
		{voltage_mode, pwm_amplitude} <= 9'h1ff;
		cyc(20);
		rchk(scs_pkg::ADDR_IRQ_STATUS, 32'h1, 32'h1);
		voltage_mode <= 1'b0;
		for (i = 0; i < 5; i++) begin
			wr_reg(scs_pkg::ADDR_COMMUTATION_MIN_VELOCITY, thr[i]);
			commutation_enable_pin <= (i == 0);
			actual_velocity <= vel[i];
			cyc(5);
			chk(32'(sensorless_commutation), 32'(dc_exp[i]));
		end
		for (i = 0; i < 3; i++) begin
			commutation_enable_pin <= (i != 1);
			above_high_velocity <= (i == 1);
			wr_reg(scs_pkg::ADDR_CONFIG, (i == 1) ? 32'h13 : 32'h3);
			wr_reg(scs_pkg::ADDR_COMM_CTRL, (i == 2) ? 32'h20 : 32'h03_0020);
			cyc(4);
			wr_reg(scs_pkg::ADDR_IRQ_CLEAR, 32'h3f);
			on_len <= 8'h50;
			cyc(200);
			rchk(scs_pkg::ADDR_IRQ_STATUS, 32'h1, 32'(i != 2));
		end
		chk(32'(adv_n > 0), 32'h1);
		summarize();
	end
endmodule // scs_stepper_commutation_status_tb
`default_nettype wire
